// ---- spm_pkg.sv ----
// Constants, field positions and state type for the serial controller block
package spm_pkg;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int GCR_ROLE_BIT = 0;
    localparam int FMT_PRESC_LSB = 8;
    localparam int FMT_PRESC_MSB = 15;
    localparam int FMT_PHASE_BIT = 16;
    localparam int FMT_POL_BIT = 17;
    localparam int DLY_C2T_LSB = 24;
    localparam int DLY_C2T_MSB = 31;
    localparam int DLY_T2C_LSB = 16;
    localparam int DLY_T2C_MSB = 23;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CNT_W = 10;
    localparam int PER_W = 9;
    localparam int CLK_MHZ = 40;
    localparam int MIN_SCLK_NS = 25;
    localparam int MIN_SCLK_CYC_RAW = (MIN_SCLK_NS * CLK_MHZ + 999) / 1000;
    localparam logic [PER_W-1:0] MIN_SCLK_CYC =
        PER_W'((MIN_SCLK_CYC_RAW < 1) ? 1 : MIN_SCLK_CYC_RAW);
    localparam logic [PER_W-1:0] PRESC_ZERO_PERIOD = 9'h002;
    localparam logic [PER_W-1:0] PRESC_OFFSET = 9'h001;
    localparam logic [CNT_W-1:0] SETUP_BASE = 10'h002;
    localparam logic [CNT_W-1:0] SETUP_KEEP_EXTRA = 10'h001;
    localparam logic [CNT_W-1:0] HOLD_BASE = 10'h001;

    // ----------------------------------------------------------------
    // Data path
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_SETUP  = 5'b00010,
        S_FIRST  = 5'b00100,
        S_SECOND = 5'b01000,
        S_HOLD   = 5'b10000
    } spm_state_t;

endpackage

// ---- spm_fifo.sv ----
// Transmit word buffer with valid and ready on both sides
`timescale 1ns/1ps
module spm_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic in_ready, next_in_ready;
    logic push, pop;

    assign push = in_valid_i && in_ready;
    assign pop = out_valid_o && out_ready_i;
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign in_ready_o = in_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        // Ready registered so the source sees back-pressure from a flop
        next_in_ready = (next_count != FULL);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else if (ce_i) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (ce_i && push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule

// ---- spm_master.sv ----
// Serial bus controller engine, delayed-phase clocking, with transmit buffer
`timescale 1ns/1ps
module spm_master #(
    parameter int W = spm_pkg::WORD_BITS,
    parameter int DEPTH = spm_pkg::FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [31:0] global_control_i,
    input wire logic [31:0] format_i,
    input wire logic [31:0] delay_i,
    input wire logic select_keep_asserted_i,
    input wire logic [W-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [W-1:0] rx_data_o,
    output logic rx_valid_o,
    output logic busy_o,
    output logic serial_clock_pin_o,
    output logic controller_out_line_o,
    input wire logic controller_in_line_i,
    output logic select_n_o
);
    import spm_pkg::*;

    localparam int BW = $clog2(W + 1);
    localparam logic [BW-1:0] LAST_BIT = BW'(W - 1);

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    function automatic logic [PER_W-1:0] sclk_period(input logic [7:0] presc);
        logic [PER_W-1:0] p;
        p = (presc == 8'h00) ? PRESC_ZERO_PERIOD : {1'b0, presc} + PRESC_OFFSET;
        // Keeps the serial clock at or above its shortest legal period
        sclk_period = (p < MIN_SCLK_CYC) ? MIN_SCLK_CYC : p;
    endfunction

    logic mode_ok;
    logic [7:0] presc_f, c2t_f, t2c_f;
    logic pol_f;
    logic [PER_W-1:0] per_f;
    logic [CNT_W-1:0] hlo_f, hhi_f, lead_f;

    assign mode_ok = global_control_i[GCR_ROLE_BIT] && format_i[FMT_PHASE_BIT];
    assign presc_f = format_i[FMT_PRESC_MSB:FMT_PRESC_LSB];
    assign pol_f = format_i[FMT_POL_BIT];
    assign c2t_f = delay_i[DLY_C2T_MSB:DLY_C2T_LSB];
    assign t2c_f = delay_i[DLY_T2C_MSB:DLY_T2C_LSB];
    assign per_f = sclk_period(presc_f);
    // odd periods give the extra cycle to the first phase
    assign hlo_f = CNT_W'(per_f >> 1);
    assign hhi_f = CNT_W'(per_f) - hlo_f;
    // lead time, one more cycle with keep and polarity 1
    assign lead_f = hlo_f + {2'b00, c2t_f} + SETUP_BASE
        + ((select_keep_asserted_i && pol_f) ? SETUP_KEEP_EXTRA : '0);

    // ----------------------------------------------------------------
    // Transmit buffer
    // ----------------------------------------------------------------
    logic f_valid, f_ready;
    logic [W-1:0] f_data;
    spm_state_t state, next_state;

    // Drained only between transfers, so a busy engine fills it up
    assign f_ready = (state == S_IDLE) && mode_ok;

    spm_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(f_data)
    );

    // ----------------------------------------------------------------
    // Transfer engine
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [BW-1:0] bits, next_bits;
    logic [W-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh, rx_data, next_rx_data;
    logic sclk, next_sclk, mosi, next_mosi, sel_n, next_sel_n;
    logic rx_valid, next_rx_valid, busy, next_busy;
    logic pol_q, next_pol_q;
    logic [CNT_W-1:0] hlo_q, next_hlo_q, hhi_q, next_hhi_q;
    logic [CNT_W-1:0] lead_q, next_lead_q, t2c_q, next_t2c_q;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_bits = bits;
        next_tx_sh = tx_sh;
        next_rx_sh = rx_sh;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_sclk = sclk;
        next_mosi = mosi;
        next_sel_n = sel_n;
        next_busy = busy;
        next_pol_q = pol_q;
        next_hlo_q = hlo_q;
        next_hhi_q = hhi_q;
        next_lead_q = lead_q;
        next_t2c_q = t2c_q;
        case (state)
            S_IDLE: begin
                // clock rests at the polarity level
                next_sclk = pol_f;
                if (mode_ok && f_valid) begin
                    next_pol_q = pol_f;
                    next_sclk = pol_f;
                    next_hlo_q = hlo_f;
                    next_hhi_q = hhi_f;
                    next_lead_q = lead_f;
                    next_t2c_q = {2'b00, t2c_f};
                    // select asserted low for the transfer
                    next_sel_n = 1'b0;
                    // first bit out a full lead ahead of the first leading edge
                    next_mosi = f_data[W-1];
                    next_tx_sh = f_data << 1;
                    next_bits = '0;
                    next_busy = 1'b1;
                    next_cnt = lead_f - 1'b1;
                    next_state = S_SETUP;
                end
            end
            S_SETUP: begin
                if (cnt == '0) begin
                    // first leading edge after the lead time
                    next_sclk = ~pol_q;
                    next_cnt = hhi_q - 1'b1;
                    next_state = S_FIRST;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            S_FIRST: begin
                if (cnt == '0) begin
                    // sample on the trailing edge: falling for 0, rising for 1
                    next_sclk = pol_q;
                    next_rx_sh = {rx_sh[W-2:0], controller_in_line_i};
                    if (bits == LAST_BIT) begin
                        next_cnt = t2c_q + HOLD_BASE - 1'b1;
                        next_state = S_HOLD;
                    end else begin
                        next_bits = bits + 1'b1;
                        next_cnt = hlo_q - 1'b1;
                        next_state = S_SECOND;
                    end
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            S_SECOND: begin
                if (cnt == '0) begin
                    // launch on leading edge, one first phase (hhi_q cycles) before sampling
                    next_sclk = ~pol_q;
                    next_mosi = tx_sh[W-1];
                    next_tx_sh = tx_sh << 1;
                    next_cnt = hhi_q - 1'b1;
                    next_state = S_FIRST;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            S_HOLD: begin
                if (cnt == '0) begin
                    // release select after the trailing gap
                    next_sel_n = 1'b1;
                    next_busy = 1'b0;
                    next_rx_data = rx_sh;
                    next_rx_valid = 1'b1;
                    next_state = S_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = S_IDLE;
                next_sel_n = 1'b1;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            cnt <= '0;
            bits <= '0;
            tx_sh <= '0;
            rx_sh <= '0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            sclk <= 1'b0;
            mosi <= 1'b0;
            sel_n <= 1'b1;
            busy <= 1'b0;
            pol_q <= 1'b0;
            hlo_q <= '0;
            hhi_q <= '0;
            lead_q <= '0;
            t2c_q <= '0;
        end else if (ce_i) begin
            state <= next_state;
            cnt <= next_cnt;
            bits <= next_bits;
            tx_sh <= next_tx_sh;
            rx_sh <= next_rx_sh;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            sclk <= next_sclk;
            mosi <= next_mosi;
            sel_n <= next_sel_n;
            busy <= next_busy;
            pol_q <= next_pol_q;
            hlo_q <= next_hlo_q;
            hhi_q <= next_hhi_q;
            lead_q <= next_lead_q;
            t2c_q <= next_t2c_q;
        end
    end

    assign serial_clock_pin_o = sclk;
    assign controller_out_line_o = mosi;
    assign select_n_o = sel_n;
    assign rx_data_o = rx_data;
    assign rx_valid_o = rx_valid;
    assign busy_o = busy;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] run_len;
    // Cycles the clock and select levels have been steady, 1 just after a change
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_len <= '0;
        end else if (ce_i) begin
            run_len <= (next_sclk != sclk || next_sel_n != sel_n) ? 10'h001 : run_len + 1'b1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i || !ce_i);
    property p_mode_gate;
        (state == S_IDLE) && !mode_ok |=> (state == S_IDLE) && select_n_o;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("transfer started outside mode");
    property p_trail_phase;
        $changed(serial_clock_pin_o) && (serial_clock_pin_o == pol_q) && !select_n_o
            |-> $past(run_len) == hhi_q;
    endproperty
    a_trail_phase: assert property (p_trail_phase) else $error("first clock phase wrong");
    property p_lead_phase;
        $changed(serial_clock_pin_o) && (serial_clock_pin_o != pol_q) && ($past(state) == S_SECOND)
            |-> $past(run_len) == hlo_q;
    endproperty
    a_lead_phase: assert property (p_lead_phase) else $error("second clock phase wrong");
    // Idle clock tracks polarity one cycle late; a frozen cycle is excused
    property p_idle_level;
        select_n_o && (state == S_IDLE) |-> (($past(state) != S_IDLE)
            ? serial_clock_pin_o == pol_q
            : (serial_clock_pin_o == $past(pol_f) || !$past(ce_i)));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");
    property p_launch;
        $changed(controller_out_line_o) |-> $fell(select_n_o)
            || ($changed(serial_clock_pin_o) && serial_clock_pin_o != pol_q);
    endproperty
    a_launch: assert property (p_launch) else $error("data changed off launch edge");
    property p_sample;
        $changed(serial_clock_pin_o) && (serial_clock_pin_o == pol_q) && !select_n_o
            |-> rx_sh[0] == $past(controller_in_line_i);
    endproperty
    a_sample: assert property (p_sample) else $error("input not sampled on trailing edge");
    property p_setup_gap;
        $changed(serial_clock_pin_o) && ($past(state) == S_SETUP) |-> $past(run_len) == lead_q;
    endproperty
    a_setup_gap: assert property (p_setup_gap) else $error("select to clock gap wrong");
    property p_hold_gap;
        $rose(select_n_o) |-> $past(run_len) == t2c_q + HOLD_BASE;
    endproperty
    a_hold_gap: assert property (p_hold_gap) else $error("clock to select gap wrong");
    // A zero trailing gap lets select rise one cycle after the last edge
    property p_select_low;
        $changed(serial_clock_pin_o) && ($past(state) != S_IDLE) |-> !select_n_o && busy_o;
    endproperty
    a_select_low: assert property (p_select_low) else $error("select high during transfer");
    property p_gap_latch;
        $fell(select_n_o) |-> lead_q == $past(lead_f) && t2c_q == {2'b00, $past(t2c_f)};
    endproperty
    a_gap_latch: assert property (p_gap_latch) else $error("gaps not taken from delay word");
endmodule

// ---- spm_target_model.sv ----
// Behavioural serial target that faces the controller engine
`timescale 1ns/1ps
module spm_target_model (
    input wire logic serial_clock_i,
    input wire logic select_n_i,
    input wire logic pol_i,
    input wire logic out_line_i,
    input wire logic [15:0] tx_word_i,
    output logic in_line_o,
    output logic [15:0] rx_word_o
);
    logic [15:0] shift_q;

    initial begin
        in_line_o = 1'b0;
        rx_word_o = 16'h0000;
        shift_q = 16'h0000;
    end

    always @(negedge select_n_i) begin
        shift_q = tx_word_i;
        in_line_o = tx_word_i[15];
    end

    // Released line flips so a stale bit is never mistaken for data
    always @(posedge select_n_i) begin
        in_line_o = ~in_line_o;
    end

    always @(serial_clock_i) begin
        if (!select_n_i && serial_clock_i === pol_i) begin
            rx_word_o = {rx_word_o[14:0], out_line_i};
            shift_q = {shift_q[14:0], 1'b0};
            in_line_o = shift_q[15];
        end
    end
endmodule

// ---- test_spm_master.sv ----
// Self-checking bench for the serial controller engine
`timescale 1ns/1ps
module test_spm_master;
    import spm_pkg::*;
    localparam int LIMIT = 20000;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] gcr = 32'h0000_0000;
    logic [31:0] fmt = 32'h0000_0000;
    logic [31:0] dly = 32'h0000_0000;
    logic keep = 1'b0;
    logic ce = 1'b1;
    logic tx_valid = 1'b0;
    logic [15:0] tx_data = 16'h0000;
    logic [15:0] tgt_tx = 16'h0000;
    logic [15:0] rx_data, tgt_rx;
    logic sclk, sdo, sdi, sel_n, tx_ready, rx_valid, busy;
    logic prev_sel = 1'b1;
    logic prev_sclk = 1'b0;
    logic cur_pol = 1'b0;
    logic [15:0] tq[$];
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int t = 0;
    int first_t = 0;
    int last_t = 0;
    int tot = 0;
    int n_done = 0;
    int bad_w = 0;
    int bad_b = 0;
    int exp_lo, exp_hi, exp_lead, exp_hold;

    always #12.5 mclk = ~mclk;

    spm_master spm_master_i (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce),
        .global_control_i(gcr), .format_i(fmt), .delay_i(dly),
        .select_keep_asserted_i(keep), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .busy_o(busy), .serial_clock_pin_o(sclk), .controller_out_line_o(sdo),
        .controller_in_line_i(sdi), .select_n_o(sel_n));

    spm_target_model spm_target_model_i (.serial_clock_i(sclk), .select_n_i(sel_n),
        .pol_i(cur_pol), .out_line_i(sdo), .tx_word_i(tgt_tx), .in_line_o(sdi),
        .rx_word_o(tgt_rx));

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cyc(input string what, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // ----------------------------------------------------------------
    // Wire monitor, sampled mid-cycle away from launching edges
    // ----------------------------------------------------------------
    always @(negedge mclk) begin
        cycles++;
        if (!sel_n && prev_sel) begin
            t = 0;
            first_t = -1;
        end else if (!sel_n) begin
            t++;
        end
        if (!sel_n && sclk !== prev_sclk) begin
            if (first_t < 0) begin
                first_t = t;
            end else if (t - last_t != ((sclk !== cur_pol) ? exp_lo : exp_hi)) begin
                bad_w++;
            end
            last_t = t;
        end
        if (sel_n && !prev_sel) begin
            tot = t + 1;
            tq.push_back(tgt_rx);
        end
        if (rx_valid === 1'b1) begin
            n_done++;
        end
        prev_sel = sel_n;
        // busy spans exactly the selected time
        if (busy !== !sel_n) begin
            bad_b++;
        end
        prev_sclk = sclk;
        // Last in the body so nothing runs after the closing report
        if (cycles >= LIMIT) begin
            error_cnt++;
            $display("mismatch timeout expected %0d seen %0d", LIMIT, cycles);
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic configure(input logic [7:0] presc, input logic [7:0] c2t,
                             input logic [7:0] t2c, input logic pol, input logic kp);
        int p;
        p = (presc == 8'h00) ? 2 : int'(presc) + 1;
        exp_lo = p / 2;
        exp_hi = p - exp_lo;
        exp_lead = exp_lo + int'(c2t) + 2 + ((kp && pol) ? 1 : 0);
        exp_hold = int'(t2c) + 1;
        cur_pol = pol;
        @(posedge mclk);
        gcr <= 32'h0000_0001;
        fmt <= {14'h0000, pol, 1'b1, presc, 8'h00};
        dly <= {c2t, t2c, 16'h0000};
        keep <= kp;
        repeat (3) @(posedge mclk);
        chk("idle clock level", {31'h0, pol}, {31'h0, sclk});
    endtask

    task automatic push(input logic [15:0] w);
        @(posedge mclk);
        tx_valid <= 1'b1;
        tx_data <= w;
        tgt_tx <= {w[7:0], w[15:8]} ^ 16'h0ff0;
        @(posedge mclk);
        tx_valid <= 1'b0;
    endtask

    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (n_done < n && k < 10000) begin
            @(posedge mclk);
            k++;
        end
        chk_cyc("completions", n, n_done);
    endtask

    task automatic run_one(input logic [15:0] w);
        int base;
        base = n_done;
        push(w);
        wait_done(base + 1);
        chk("word from target", {16'h0, {w[7:0], w[15:8]} ^ 16'h0ff0}, {16'h0, rx_data});
        chk("word at target", {16'h0, w}, {16'h0, tgt_rx});
        chk_cyc("lead cycles", exp_lead, first_t);
        chk_cyc("hold cycles", exp_hold, tot - last_t);
        chk_cyc("frame cycles", exp_lead + 16 * exp_hi + 15 * exp_lo + exp_hold, tot);
        chk_cyc("phase errors", 0, bad_w);
        chk("select released", 32'h1, {31'h0, sel_n});
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    logic [7:0] presc_t[6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'hff, 8'h03};
    logic [7:0] c2_t[6] = '{8'h00, 8'h03, 8'h00, 8'h07, 8'hff, 8'h01};
    logic [7:0] t2_t[6] = '{8'h00, 8'h02, 8'h05, 8'h00, 8'hff, 8'h01};
    logic pol_t[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic kp_t[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0] w_t[9] = '{16'h8001, 16'h7ffe, 16'ha5c3, 16'h0f0f, 16'h1234,
                            16'hfedc, 16'h5555, 16'haaaa, 16'h0001};

    initial begin
        int base;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("select after reset", 32'h1, {31'h0, sel_n});
        for (int i = 0; i < 6; i++) begin
            configure(presc_t[i], c2_t[i], t2_t[i], pol_t[i], kp_t[i]);
            run_one(w_t[i]);
        end
        configure(8'h01, 8'h00, 8'h00, 1'b0, 1'b0);
        @(posedge mclk);
        gcr <= 32'h0000_0000;
        tgt_tx <= 16'hc33c;
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk);
            tx_valid <= 1'b1;
            tx_data <= w_t[i];
        end
        @(posedge mclk);
        tx_valid <= 1'b0;
        @(posedge mclk);
        chk("buffer full", 32'h0, {31'h0, tx_ready});
        repeat (40) @(posedge mclk);
        chk("role off idle", 32'h1, {31'h0, sel_n});
        gcr <= 32'h0000_0001;
        fmt[FMT_PHASE_BIT] <= 1'b0;
        repeat (40) @(posedge mclk);
        chk("phase off idle", 32'h1, {31'h0, sel_n});
        tq.delete();
        base = n_done;
        fmt[FMT_PHASE_BIT] <= 1'b1;
        wait_done(base + 8);
        repeat (100) @(posedge mclk);
        chk_cyc("refused word dropped", base + 8, n_done);
        chk_cyc("frames seen", 8, tq.size());
        for (int i = 0; i < 8 && i < tq.size(); i++) begin
            chk("burst word order", {16'h0, w_t[i]}, {16'h0, tq[i]});
        end
        chk("burst target word", {16'h0, 16'hc33c}, {16'h0, rx_data});
        chk("buffer drained", 32'h1, {31'h0, tx_ready});
        chk("idle busy", 32'h0, {31'h0, busy});
        // Clock enable low freezes engine and buffer: no idle tracking, no store
        ce <= 1'b0;
        fmt[FMT_POL_BIT] <= 1'b1;
        tx_valid <= 1'b1;
        tx_data <= 16'h3c3c;
        repeat (4) @(posedge mclk);
        chk("frozen clock level", 32'h0, {31'h0, sclk});
        tx_valid <= 1'b0;
        ce <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("clock level after freeze", 32'h1, {31'h0, sclk});
        chk("no frame from frozen word", 32'h1, {31'h0, sel_n});
        chk_cyc("frozen word dropped", base + 8, n_done);
        chk_cyc("phase errors", 0, bad_w);
        chk_cyc("busy against select", 0, bad_b);
        end_of_test();
    end
endmodule
